// [bench/mss_chipset.sv]
// Chipset model: raises management interrupts and suspend requests
`timescale 1ns/1ns
`default_nettype none
module mss_chipset (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Bench commands
  input wire logic smi_go,
  input wire logic suspend_request_n_go,
  // Chipset pins
  input wire logic line_n,
  output logic pull_low,
  output logic suspend_request_n
);
  logic [2:0] low_q;
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      low_q <= 3'h0;
    else if (smi_go && line_n && low_q == 3'h0)
      low_q <= 3'h5;
    else if (low_q != 3'h0)
      low_q <= low_q - 3'h1;
  end
  assign pull_low = (low_q != 3'h0);
  assign suspend_request_n = !suspend_request_n_go;
endmodule
`default_nettype wire

// [bench/tb.sv]
// Testbench for the management mode and suspend controller
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clock, clk_run, rst_b, halt_opcode, resume_opcode, pipeline_idle, suspend_request_n_ack_enable;
  logic seg_save_req, cycle_req, region_wr, smi_go, suspend_request_n_go, pull_low, line_n;
  logic [31:0] cycle_addr, region_base_in, region_size_in, base, state_save_addr, fetch_addr;
  logic suspend_request_n, suspend_ack_n, mgmt_interrupt_n_out, mgmt_interrupt_n_oe;
  logic mgmt_region_strobe_n, normal_addr_strobe_n, system_mgmt_mode, real_mode_force;
  logic core_stall, state_save_req, seg_save_ack, fetch_redirect;
  int err_count = 0;
  int check_count = 0;
  int seed, n, i;
  // Pull-up on the shared interrupt line
  assign line_n = mgmt_interrupt_n_oe ? mgmt_interrupt_n_out : !pull_low;
  mss_ctrl uut (.clock(clock), .rst_b(rst_b), .halt_opcode(halt_opcode),
    .resume_opcode(resume_opcode), .pipeline_idle(pipeline_idle),
    .suspend_request_n_ack_enable(suspend_request_n_ack_enable), .seg_save_req(seg_save_req), .cycle_req(cycle_req),
    .cycle_addr(cycle_addr), .region_wr(region_wr), .region_base_in(region_base_in),
    .region_size_in(region_size_in), .suspend_request_n(suspend_request_n),
    .suspend_ack_n(suspend_ack_n), .mgmt_interrupt_n_in(line_n),
    .mgmt_interrupt_n_out(mgmt_interrupt_n_out), .mgmt_interrupt_n_oe(mgmt_interrupt_n_oe),
    .mgmt_region_strobe_n(mgmt_region_strobe_n), .normal_addr_strobe_n(normal_addr_strobe_n),
    .system_mgmt_mode(system_mgmt_mode), .real_mode_force(real_mode_force),
    .core_stall(core_stall), .state_save_req(state_save_req),
    .state_save_addr(state_save_addr), .seg_save_ack(seg_save_ack),
    .fetch_redirect(fetch_redirect), .fetch_addr(fetch_addr));
  mss_chipset chip (.clock(clock), .rst_b(rst_b), .smi_go(smi_go), .suspend_request_n_go(suspend_request_n_go),
    .line_n(line_n), .pull_low(pull_low), .suspend_request_n(suspend_request_n));
  initial
  begin
    clock = 1'b0;
    clk_run = 1'b1;
    forever #50 if (clk_run) clock = ~clock;
  end
  // Saved state sits just below the top of the region
  function automatic logic [31:0] exp_save(input logic [31:0] b, input logic [31:0] s);
    exp_save = b + s - mss_pkg::SAVE_AREA_OFFSET;
  endfunction
  function automatic logic sig(input int s);
    case (s)
      0: sig = mgmt_interrupt_n_oe;
      1: sig = fetch_redirect;
      2: sig = mgmt_interrupt_n_out;
      3: sig = suspend_ack_n;
      4: sig = mgmt_region_strobe_n;
      5: sig = normal_addr_strobe_n;
      default: sig = seg_save_ack;
    endcase
  endfunction
  task automatic end_sim();
    $display("Checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("Error: %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  // Bounded wait; n counts falling edges passed
  task automatic wait_sig(input int s, input logic v, input int lim);
    n = 0;
    while (sig(s) !== v)
    begin
      @(negedge clock);
      n++;
      if (n > lim)
      begin
        $display("Error: wait on signal %0d expected %b seen %b", s, v, sig(s));
        err_count++;
        end_sim();
      end
    end
  endtask
  task automatic pulse(input int s);
    @(negedge clock);
    case (s)
      0: halt_opcode = 1'b1;
      1: resume_opcode = 1'b1;
      2: cycle_req = 1'b1;
      3: region_wr = 1'b1;
      default: smi_go = 1'b1;
    endcase
    @(negedge clock);
    {halt_opcode, resume_opcode, cycle_req, region_wr, smi_go} = 5'h00;
  endtask
  task automatic program_region();
    base = $random(seed) & 32'h7fff_f000;
    region_base_in = base;
    region_size_in = 32'h0000_2000;
    pulse(3);
  endtask
  initial
  begin
    seed = 32'hb7f72ce8;
    {rst_b, halt_opcode, resume_opcode, pipeline_idle, suspend_request_n_ack_enable} = 5'h00;
    {seg_save_req, cycle_req, region_wr, smi_go, suspend_request_n_go} = 5'h00;
    {cycle_addr, region_base_in, region_size_in} = 96'h0;
    repeat (3) @(posedge clock);
    chk("suspend ack", 32'h1, suspend_ack_n);
    chk("line enable", 32'h0, mgmt_interrupt_n_oe);
    @(negedge clock);
    rst_b = 1'b1;
    program_region();
    cycle_addr = base + 32'h10;
    pulse(2);
    wait_sig(5, 1'b0, 2);
    chk("region strobe", 32'h1, mgmt_region_strobe_n);
    suspend_request_n_go = 1'b1;
    repeat (4) @(negedge clock);
    chk("ack while draining", 32'h1, suspend_ack_n);
    chk("stall", 32'h1, core_stall);
    pipeline_idle = 1'b1;
    wait_sig(3, 1'b0, 3);
    clk_run = 1'b0;
    #1030;
    chk("ack with clock stopped", 32'h0, suspend_ack_n);
    chk("stall with clock stopped", 32'h1, core_stall);
    clk_run = 1'b1;
    @(negedge clock);
    chk("ack after clock restart", 32'h0, suspend_ack_n);
    suspend_request_n_go = 1'b0;
    wait_sig(3, 1'b1, 3);
    $display("Suspend test done");
    for (i = 0; i < 2; i++)
    begin
      if (i == 1)
        program_region();
      pulse(4);
      wait_sig(0, 1'b1, 8);
      chk("line out", 32'h0, mgmt_interrupt_n_out);
      chk("mgmt mode", 32'h1, system_mgmt_mode);
      chk("real mode", 32'h1, real_mode_force);
      chk("save req", 32'h1, state_save_req);
      chk("save addr", exp_save(base, region_size_in), state_save_addr);
      wait_sig(1, 1'b1, 80);
      chk("entry clocks", 32'd70, n);
      chk("fetch addr", base, fetch_addr);
      cycle_addr = base + 32'h0000_1ffc;
      pulse(2);
      wait_sig(4, 1'b0, 2);
      chk("normal strobe", 32'h1, normal_addr_strobe_n);
      cycle_addr = base + 32'h0000_2000;
      pulse(2);
      wait_sig(5, 1'b0, 2);
      chk("region strobe", 32'h1, mgmt_region_strobe_n);
      chk("line held", 32'h0, line_n);
      region_base_in = ~base;
      pulse(3);
      cycle_addr = base;
      pulse(2);
      wait_sig(4, 1'b0, 2);
      chk("locked region", 32'h1, normal_addr_strobe_n);
      seg_save_req = 1'b1;
      wait_sig(6, 1'b1, 3);
      seg_save_req = 1'b0;
      pulse(1);
      wait_sig(2, 1'b1, 80);
      chk("exit clocks", 32'd70, n);
      wait_sig(0, 1'b0, 4);
      chk("high drive clocks", 32'd2, n);
      chk("mgmt mode left", 32'h0, system_mgmt_mode);
      $display("Management pass %0d done", i);
    end
    suspend_request_n_ack_enable = 1'b1;
    pulse(0);
    wait_sig(3, 1'b0, 3);
    pulse(4);
    wait_sig(0, 1'b1, 8);
    $display("Halt test done");
    end_sim();
  end
endmodule
`default_nettype wire

// [rtl/mss_ctrl.sv]
// Management mode entry/exit and suspend controller
`timescale 1ns/1ns
`default_nettype none
//
// Functional notes
// - State holds when clock slowed or stopped.
// - Restarted clock resumes the interrupted instruction.
// - Halt enters suspend, acknowledges if enabled.
// - Suspend request drains work, then acknowledges.
// - Handler entry forces real-address mode.
// - Region base and size are programmable.
// - Minimal save; entry plus exit 140 clocks.
// - Extra segment saves on handler request.
// - Region base register is 32 bits.
// - Region relocatable and resizable at run time.
// - Device holds interrupt line low during handler.
// - Resume drives line high two clocks.
// - Management strobe replaces normal strobe inside region while in handler.
module mss_ctrl (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Core pipeline status
  input wire logic halt_opcode,
  input wire logic resume_opcode,
  input wire logic pipeline_idle,
  input wire logic suspend_request_n_ack_enable,
  input wire logic seg_save_req,
  // Bus cycle request
  input wire logic cycle_req,
  input wire logic [31:0] cycle_addr,
  // Region programming
  input wire logic region_wr,
  input wire logic [31:0] region_base_in,
  input wire logic [31:0] region_size_in,
  // Chipset pins
  input wire logic suspend_request_n,
  output logic suspend_ack_n,
  input wire logic mgmt_interrupt_n_in,
  output logic mgmt_interrupt_n_out,
  output logic mgmt_interrupt_n_oe,
  output logic mgmt_region_strobe_n,
  output logic normal_addr_strobe_n,
  // Core control
  output logic system_mgmt_mode,
  output logic real_mode_force,
  output logic core_stall,
  output logic state_save_req,
  output logic [31:0] state_save_addr,
  output logic seg_save_ack,
  output logic fetch_redirect,
  output logic [31:0] fetch_addr
);

  mss_pkg::mss_regs_t r_q, r_d;

  // ----------------------------------------
  // Region decode
  // ----------------------------------------
  function automatic logic in_region(input logic [31:0] a, input logic [31:0] b,
                                     input logic [31:0] s);
    logic [31:0] off;
    off = a - b;
    in_region = (s >= mss_pkg::REGION_MIN_SIZE) && (off < s);
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    r_d = r_q;
    r_d.save_req = 1'b0;
    r_d.seg_save_ack = 1'b0;
    r_d.fetch_redirect = 1'b0;
    r_d.mgmt_strobe_n = 1'b1;
    r_d.norm_strobe_n = 1'b1;
    if (!mgmt_interrupt_n_in && !r_q.smi_oe)
    begin
      if (r_q.smi_low != 8'hff)
      begin
        r_d.smi_low = r_q.smi_low + mss_pkg::CNT_ONE;
      end
    end
    else
    begin
      r_d.smi_low = mss_pkg::CNT_ZERO;
    end
    // Reprogramming blocked only in the handler state
    if (region_wr && r_q.st != mss_pkg::MSS_HANDLER)
    begin
      r_d.base = region_base_in;
      r_d.size = region_size_in;
    end
    case (r_q.st)
      mss_pkg::MSS_RUN:
      begin
        if (r_q.smi_low + mss_pkg::CNT_ONE >= mss_pkg::SMI_LOW_CNT
            && !mgmt_interrupt_n_in)
        begin
          r_d.st = mss_pkg::MSS_ENTRY;
          r_d.cnt = mss_pkg::ENTRY_CNT;
          r_d.smi_oe = 1'b1;
          r_d.smi_out = 1'b0;
          r_d.real_mode = 1'b1;
          r_d.save_req = 1'b1;
          r_d.save_addr = r_q.base + r_q.size - mss_pkg::SAVE_AREA_OFFSET;
        end
        else if (halt_opcode)
        begin
          r_d.st = mss_pkg::MSS_SUSPEND;
          r_d.from_halt = 1'b1;
          r_d.suspend_request_n_ack_n = !suspend_request_n_ack_enable;
        end
        else if (!suspend_request_n)
        begin
          r_d.st = mss_pkg::MSS_DRAIN;
        end
      end
      mss_pkg::MSS_DRAIN:
      begin
        if (pipeline_idle)
        begin
          r_d.st = mss_pkg::MSS_SUSPEND;
          r_d.from_halt = 1'b0;
          r_d.suspend_request_n_ack_n = 1'b0;
        end
      end
      mss_pkg::MSS_SUSPEND:
      begin
        if (!r_q.from_halt && suspend_request_n)
        begin
          r_d.st = mss_pkg::MSS_RUN;
          r_d.suspend_request_n_ack_n = 1'b1;
        end
        else if (r_q.from_halt && !mgmt_interrupt_n_in)
        begin
          r_d.st = mss_pkg::MSS_RUN;
          r_d.suspend_request_n_ack_n = 1'b1;
          r_d.from_halt = 1'b0;
        end
      end
      mss_pkg::MSS_ENTRY:
      begin
        r_d.cnt = r_q.cnt - mss_pkg::CNT_ONE;
        if (r_q.cnt == mss_pkg::CNT_ONE)
        begin
          r_d.st = mss_pkg::MSS_HANDLER;
          r_d.fetch_redirect = 1'b1;
          r_d.fetch_addr = r_q.base;
        end
      end
      mss_pkg::MSS_HANDLER:
      begin
        r_d.seg_save_ack = seg_save_req;
        if (resume_opcode)
        begin
          r_d.st = mss_pkg::MSS_EXIT;
          r_d.cnt = mss_pkg::EXIT_CNT;
        end
      end
      mss_pkg::MSS_EXIT:
      begin
        r_d.cnt = r_q.cnt - mss_pkg::CNT_ONE;
        if (r_q.cnt == mss_pkg::CNT_ONE)
        begin
          r_d.st = mss_pkg::MSS_RELEASE;
          r_d.cnt = mss_pkg::RESUME_CNT;
          r_d.smi_out = 1'b1;
          r_d.real_mode = 1'b0;
        end
      end
      mss_pkg::MSS_RELEASE:
      begin
        r_d.cnt = r_q.cnt - mss_pkg::CNT_ONE;
        if (r_q.cnt == mss_pkg::CNT_ONE)
        begin
          r_d.st = mss_pkg::MSS_RUN;
          r_d.smi_oe = 1'b0;
          r_d.smi_out = 1'b0;
        end
      end
      default:
      begin
        r_d.st = mss_pkg::MSS_RUN;
      end
    endcase
    // Address strobe steering
    if (cycle_req)
    begin
      if (r_q.st == mss_pkg::MSS_HANDLER && in_region(cycle_addr, r_q.base, r_q.size))
      begin
        r_d.mgmt_strobe_n = 1'b0;
      end
      else
      begin
        r_d.norm_strobe_n = 1'b0;
      end
    end
    // Core held off while draining, suspended, entering or leaving
    r_d.stall = !r_d.suspend_request_n_ack_n || (r_d.st != mss_pkg::MSS_RUN
                && r_d.st != mss_pkg::MSS_HANDLER);
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Fully static: nothing but the asynchronous reset changes without a clock edge
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      r_q <= '{st: mss_pkg::MSS_RUN, cnt: mss_pkg::CNT_ZERO, smi_low: mss_pkg::CNT_ZERO,
               base: mss_pkg::RESET_BASE, size: mss_pkg::RESET_SIZE, real_mode: 1'b0,
               suspend_request_n_ack_n: 1'b1, smi_out: 1'b0, smi_oe: 1'b0, mgmt_strobe_n: 1'b1,
               norm_strobe_n: 1'b1, save_req: 1'b0, save_addr: 32'h0000_0000,
               seg_save_ack: 1'b0, fetch_addr: 32'h0000_0000, fetch_redirect: 1'b0,
               from_halt: 1'b0, stall: 1'b0};
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign suspend_ack_n = r_q.suspend_request_n_ack_n;
  assign mgmt_interrupt_n_out = r_q.smi_out;
  assign mgmt_interrupt_n_oe = r_q.smi_oe;
  assign mgmt_region_strobe_n = r_q.mgmt_strobe_n;
  assign normal_addr_strobe_n = r_q.norm_strobe_n;
  assign system_mgmt_mode = r_q.smi_oe;
  assign real_mode_force = r_q.real_mode;
  assign core_stall = r_q.stall;
  assign state_save_req = r_q.save_req;
  assign state_save_addr = r_q.save_addr;
  assign seg_save_ack = r_q.seg_save_ack;
  assign fetch_redirect = r_q.fetch_redirect;
  assign fetch_addr = r_q.fetch_addr;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_SMI_HELD_LOW: assert property (@(posedge clock) disable iff (!rst_b)
    r_q.st == mss_pkg::MSS_HANDLER |-> mgmt_interrupt_n_oe && !mgmt_interrupt_n_out)
    else $error("interrupt line not held low in handler");
  AST_RESUME_HIGH: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(mgmt_interrupt_n_out) |-> mgmt_interrupt_n_oe [*2] ##1 !mgmt_interrupt_n_oe)
    else $error("resume high pulse not two clocks");
  AST_REAL_MODE: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(mgmt_interrupt_n_oe) |-> real_mode_force)
    else $error("real mode not forced on entry");
  AST_ENTRY_TIME: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(mgmt_interrupt_n_oe) |-> ##70 fetch_redirect)
    else $error("entry time wrong");
  AST_FETCH_BASE: assert property (@(posedge clock) disable iff (!rst_b)
    fetch_redirect |-> fetch_addr == r_q.base)
    else $error("handler not at region base");
  AST_SUSPEND_REQUEST_N_ACK: assert property (@(posedge clock) disable iff (!rst_b)
    r_q.st == mss_pkg::MSS_DRAIN && pipeline_idle |=> !suspend_ack_n)
    else $error("suspend ack missing after drain");
  AST_SUSPEND_REQUEST_N_RELEASE: assert property (@(posedge clock) disable iff (!rst_b)
    r_q.st == mss_pkg::MSS_SUSPEND && !r_q.from_halt && suspend_request_n |=> suspend_ack_n)
    else $error("suspend ack not released");
  AST_STROBE_EXCL: assert property (@(posedge clock) disable iff (!rst_b)
    $past(cycle_req) == (mgmt_region_strobe_n != normal_addr_strobe_n))
    else $error("strobes do not match one per bus cycle");
  AST_HALT_SUSPEND_REQUEST_N: assert property (@(posedge clock) disable iff (!rst_b)
    r_q.st == mss_pkg::MSS_RUN && halt_opcode && mgmt_interrupt_n_in && suspend_request_n_ack_enable
    |=> !suspend_ack_n)
    else $error("halt did not acknowledge");
  AST_EXIT_TIME: assert property (@(posedge clock) disable iff (!rst_b)
    r_q.st == mss_pkg::MSS_HANDLER && resume_opcode
    |-> ##70 !mgmt_interrupt_n_out ##1 mgmt_interrupt_n_out)
    else $error("exit time wrong");
  AST_NO_REENTRY: assert property (@(posedge clock) disable iff (!rst_b)
    system_mgmt_mode && $past(system_mgmt_mode) |-> !state_save_req)
    else $error("second entry while in management mode");
  AST_REGION_LOCK: assert property (@(posedge clock) disable iff (!rst_b)
    r_q.st == mss_pkg::MSS_HANDLER && region_wr |=> $stable(r_q.base) && $stable(r_q.size))
    else $error("region changed inside handler");
  AST_SUSPEND_REQUEST_N_HOLD: assert property (@(posedge clock) disable iff (!rst_b)
    r_q.st == mss_pkg::MSS_SUSPEND && !r_q.from_halt && !suspend_request_n
    |=> !suspend_ack_n && core_stall)
    else $error("suspend not held while requested");
  AST_REAL_CLEAR: assert property (@(posedge clock) disable iff (!rst_b)
    $fell(mgmt_interrupt_n_oe) |-> !real_mode_force)
    else $error("real mode still forced after exit");

  // ----------------------------------------
  // Cover points
  // ----------------------------------------
  COV_ENTRY: cover property (@(posedge clock) disable iff (!rst_b) $rose(mgmt_interrupt_n_oe));
  COV_EXIT: cover property (@(posedge clock) disable iff (!rst_b) $fell(mgmt_interrupt_n_oe));
  COV_SUSPEND_REQUEST_N: cover property (@(posedge clock) disable iff (!rst_b) $fell(suspend_ack_n));
  COV_MSTROBE: cover property (@(posedge clock) disable iff (!rst_b) !mgmt_region_strobe_n);
  COV_HALT_WAKE: cover property (@(posedge clock) disable iff (!rst_b)
    r_q.st == mss_pkg::MSS_SUSPEND && r_q.from_halt && !mgmt_interrupt_n_in);
endmodule
`default_nettype wire

// [rtl/mss_pkg.sv]
// Package: constants and types for management mode and suspend control
package mss_pkg;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned REGION_MIN_SIZE = 32'h0000_1000;
  localparam logic [31:0] SAVE_AREA_OFFSET = 32'h0000_0030;
  // Entry plus exit overhead in clocks
  localparam int unsigned MGMT_OVERHEAD_CLOCKS = 140;
  localparam int unsigned ENTRY_CLOCKS = MGMT_OVERHEAD_CLOCKS / 2;
  localparam int unsigned EXIT_CLOCKS = MGMT_OVERHEAD_CLOCKS - ENTRY_CLOCKS;
  localparam int unsigned SMI_MIN_LOW = 4;
  localparam int unsigned RESUME_HIGH_CLOCKS = 2;
  localparam int unsigned CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic [CNT_W-1:0] ENTRY_CNT = 8'(ENTRY_CLOCKS);
  localparam logic [CNT_W-1:0] EXIT_CNT = 8'(EXIT_CLOCKS);
  localparam logic [CNT_W-1:0] SMI_LOW_CNT = 8'(SMI_MIN_LOW);
  localparam logic [CNT_W-1:0] RESUME_CNT = 8'(RESUME_HIGH_CLOCKS);
  localparam logic [31:0] RESET_BASE = 32'h0000_0000;
  localparam logic [31:0] RESET_SIZE = 32'h0000_0000;

  typedef enum logic [6:0] {
    MSS_RUN     = 7'b000_0001,
    MSS_DRAIN   = 7'b000_0010,
    MSS_SUSPEND = 7'b000_0100,
    MSS_ENTRY   = 7'b000_1000,
    MSS_HANDLER = 7'b001_0000,
    MSS_EXIT    = 7'b010_0000,
    MSS_RELEASE = 7'b100_0000
  } mss_state_t;

  typedef struct packed {
    mss_state_t st;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] smi_low;
    logic [31:0] base;
    logic [31:0] size;
    logic real_mode;
    logic suspend_request_n_ack_n;
    logic smi_out;
    logic smi_oe;
    logic mgmt_strobe_n;
    logic norm_strobe_n;
    logic save_req;
    logic [31:0] save_addr;
    logic seg_save_ack;
    logic [31:0] fetch_addr;
    logic fetch_redirect;
    logic from_halt;
    logic stall;
  } mss_regs_t;
endpackage
